// *** include/dma_chan_if.sv ***
`timescale 1ns/1ps
// Carries the selected channel's programming to the transfer sequencer
interface dma_chan_if;
    import dma_core_pkg::*;
    logic start;
    logic [CH_IDX_W-1:0] chan;
    logic [MODE_W-1:0] mode;
    logic [MEM_ADDR_W-1:0] mem_addr;
    logic [IO_ADDR_W-1:0] io_addr;
    logic [COUNT_W-1:0] count;
    logic step;
    logic [MEM_ADDR_W-1:0] next_mem_addr;
    logic [COUNT_W-1:0] next_count;
    logic tc;
    logic busy;

    modport ctrl (output start, chan, mode, mem_addr, io_addr, count,
                  input step, next_mem_addr, next_count, tc, busy);
    modport seq (input start, chan, mode, mem_addr, io_addr, count,
                 output step, next_mem_addr, next_count, tc, busy);
endinterface

// *** include/dma_core_pkg.sv ***
package dma_core_pkg;
    localparam int NUM_CHANNELS = 8;
    localparam int MEM_ADDR_W = 24;
    localparam int IO_ADDR_W = 16;
    localparam int COUNT_W = 16;
    localparam int DATA_W = 16;
    localparam int CH_IDX_W = 3;
    localparam int LEVEL_W = 4;

    // Register map: per-channel block of words at CH_BASE + ch * CH_STRIDE
    localparam logic [11:0] CH_BASE = 12'h000;
    localparam logic [11:0] CH_STRIDE = 12'h020;
    localparam logic [4:0] CH_MEM_ADDR = 5'h00;
    localparam logic [4:0] CH_IO_ADDR = 5'h04;
    localparam logic [4:0] CH_COUNT = 5'h08;
    localparam logic [4:0] CH_MODE = 5'h0C;
    localparam logic [4:0] CH_CUR_ADDR = 5'h10;
    localparam logic [4:0] CH_CUR_COUNT = 5'h14;
    localparam logic [11:0] REG_CONTROL = 12'h100;
    localparam logic [11:0] REG_STATUS = 12'h104;
    localparam logic [11:0] REG_IRQ_CLEAR = 12'h108;
    localparam logic [11:0] REG_IRQ_ENABLE = 12'h10C;
    localparam logic [11:0] REG_LEVEL0 = 12'h110;
    localparam logic [11:0] REG_LEVEL4 = 12'h114;

    // Mode register fields
    localparam int MODE_ENABLE = 0;
    localparam int MODE_WORD = 1;
    localparam int MODE_MEM_TO_IO = 2;
    localparam int MODE_VERIFY = 3;
    localparam int MODE_DECREMENT = 4;
    localparam int MODE_BURST = 5;
    localparam int MODE_USE_IO_ADDR = 6;
    localparam int MODE_W = 7;

    // Control register fields
    localparam int CTRL_RUN = 0;
    localparam int CTRL_W = 1;

    // Status register: tc bits 7..0, busy bit
    localparam int STAT_BUSY = 8;

    localparam logic [LEVEL_W-1:0] LEVEL0_RESET = 4'h0;
    localparam logic [LEVEL_W-1:0] LEVEL4_RESET = 4'h4;
    localparam logic [IO_ADDR_W-1:0] IO_ADDR_FORCED = 16'h0000;
    localparam logic [MEM_ADDR_W-1:0] ADDR_STEP_BYTE = 24'h00_0001;
    localparam logic [MEM_ADDR_W-1:0] ADDR_STEP_WORD = 24'h00_0002;
    localparam logic [31:0] BAD_READ = 32'h0000_0000;

    typedef enum logic [2:0] {
        XF_IDLE,
        XF_READ,
        XF_WRITE,
        XF_NEXT,
        XF_DONE
    } xfer_state_t;
endpackage

// *** rtl/dma_core.sv ***
// The register addresses and register access over APB were chosen for this implementation.
`timescale 1ns/1ps
// Overview of operation
// - Host reads and writes registers over bus
// - Transfer starts only for granted, programmed channel
// - Single or burst service per channel
// - Channel ready low stretches the access
// - 24-bit memory, 16-bit I/O addresses
// - Eight independently programmed channels
// - Read cycle latches, then separate write
// - Byte or word width per channel
// - Only 8- or 16-bit slaves
// - Two channels have programmable levels
// - Either direction on any channel
// - I/O address programmed or forced zero
// - Verify reads memory, updates, signals terminal
// - Count plus one transfers performed
// - Memory address steps up or down
// - I/O address never changes
// - One shared hidden 16-bit holding latch
module dma_core
    import dma_core_pkg::*;
#(
    parameter int CHANNELS = NUM_CHANNELS
)
(
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic arb_grant,
    input wire logic [LEVEL_W-1:0] arb_level,
    input wire logic slot_channel_ready,
    input wire logic [DATA_W-1:0] bus_rdata,
    output logic bus_cycle,
    output logic bus_mem,
    output logic bus_write,
    output logic bus_word,
    output logic [MEM_ADDR_W-1:0] bus_addr,
    output logic [DATA_W-1:0] bus_wdata,
    output logic [CH_IDX_W-1:0] active_chan,
    output logic busy,
    output logic irq
);
    // ************************************************
    // State
    // ************************************************
    typedef struct packed {
        logic [CHANNELS-1:0][MEM_ADDR_W-1:0] base_addr;
        logic [CHANNELS-1:0][MEM_ADDR_W-1:0] cur_addr;
        logic [CHANNELS-1:0][IO_ADDR_W-1:0] io_addr;
        logic [CHANNELS-1:0][COUNT_W-1:0] base_count;
        logic [CHANNELS-1:0][COUNT_W-1:0] cur_count;
        logic [CHANNELS-1:0][MODE_W-1:0] mode;
        logic [CTRL_W-1:0] control;
        logic [CHANNELS-1:0] tc_status;
        logic [CHANNELS-1:0] irq_en;
        logic [LEVEL_W-1:0] level0;
        logic [LEVEL_W-1:0] level4;
        logic [CH_IDX_W-1:0] chan;
        logic start;
        logic [31:0] rdata;
    } core_state_t;

    core_state_t r, next_r;
    dma_chan_if ch_bus ();

    logic wr_en;
    logic rd_en;
    logic [CHANNELS-1:0] level_hit;
    logic hit;
    logic [CH_IDX_W-1:0] hit_chan;
    logic in_ch_block;
    logic [CH_IDX_W-1:0] reg_chan;
    logic [4:0] reg_off;

    // ************************************************
    // Grant decode
    // ************************************************
    // Channels 0 and 4 carry programmable levels; others use their index
    genvar gi;
    generate
        for (gi = 0; gi < CHANNELS; gi++) begin : g_level
            if (gi == 0) begin : g_prog0
                assign level_hit[gi] = (arb_level == r.level0);
            end else if (gi == 4) begin : g_prog4
                assign level_hit[gi] = (arb_level == r.level4);
            end else begin : g_fixed
                assign level_hit[gi] = (arb_level == LEVEL_W'(gi));
            end
        end
    endgenerate

    always_comb begin
        hit = 1'b0;
        hit_chan = '0;
        for (int i = CHANNELS - 1; i >= 0; i--) begin
            if (level_hit[i] && r.mode[i][MODE_ENABLE]) begin
                hit = 1'b1;
                hit_chan = CH_IDX_W'(i);
            end
        end
    end

    // ************************************************
    // Register access
    // ************************************************
    assign wr_en = psel && penable && pwrite;
    assign rd_en = psel && !penable && !pwrite;
    assign in_ch_block = (paddr < REG_CONTROL);
    assign reg_chan = paddr[7:5];
    assign reg_off = paddr[4:0];

    always_comb begin
        next_r = r;
        next_r.start = 1'b0;
        // Writes first so the hardware update below overrides on a clash
        if (wr_en) begin
            if (in_ch_block && reg_off == CH_MEM_ADDR) begin
                next_r.base_addr[reg_chan] = pwdata[MEM_ADDR_W-1:0];
                next_r.cur_addr[reg_chan] = pwdata[MEM_ADDR_W-1:0];
            end else if (in_ch_block && reg_off == CH_IO_ADDR) begin
                next_r.io_addr[reg_chan] = pwdata[IO_ADDR_W-1:0];
            end else if (in_ch_block && reg_off == CH_COUNT) begin
                next_r.base_count[reg_chan] = pwdata[COUNT_W-1:0];
                next_r.cur_count[reg_chan] = pwdata[COUNT_W-1:0];
            end else if (in_ch_block && reg_off == CH_MODE) begin
                next_r.mode[reg_chan] = pwdata[MODE_W-1:0];
            end else if (paddr == REG_CONTROL) begin
                next_r.control = pwdata[CTRL_W-1:0];
            end else if (paddr == REG_IRQ_CLEAR) begin
                next_r.tc_status = r.tc_status & ~pwdata[CHANNELS-1:0];
            end else if (paddr == REG_IRQ_ENABLE) begin
                next_r.irq_en = pwdata[CHANNELS-1:0];
            end else if (paddr == REG_LEVEL0) begin
                next_r.level0 = pwdata[LEVEL_W-1:0];
            end else if (paddr == REG_LEVEL4) begin
                next_r.level4 = pwdata[LEVEL_W-1:0];
            end
        end

        if (rd_en) begin
            next_r.rdata = BAD_READ;
            if (in_ch_block && reg_off == CH_MEM_ADDR) begin
                next_r.rdata = 32'(r.base_addr[reg_chan]);
            end else if (in_ch_block && reg_off == CH_IO_ADDR) begin
                next_r.rdata = 32'(r.io_addr[reg_chan]);
            end else if (in_ch_block && reg_off == CH_COUNT) begin
                next_r.rdata = 32'(r.base_count[reg_chan]);
            end else if (in_ch_block && reg_off == CH_MODE) begin
                next_r.rdata = 32'(r.mode[reg_chan]);
            end else if (in_ch_block && reg_off == CH_CUR_ADDR) begin
                next_r.rdata = 32'(r.cur_addr[reg_chan]);
            end else if (in_ch_block && reg_off == CH_CUR_COUNT) begin
                next_r.rdata = 32'(r.cur_count[reg_chan]);
            end else if (paddr == REG_CONTROL) begin
                next_r.rdata = 32'(r.control);
            end else if (paddr == REG_STATUS) begin
                next_r.rdata = 32'({ch_bus.busy, r.tc_status});
            end else if (paddr == REG_IRQ_ENABLE) begin
                next_r.rdata = 32'(r.irq_en);
            end else if (paddr == REG_LEVEL0) begin
                next_r.rdata = 32'(r.level0);
            end else if (paddr == REG_LEVEL4) begin
                next_r.rdata = 32'(r.level4);
            end
        end

        // Launch only on a won grant for an enabled, programmed channel
        if (r.control[CTRL_RUN] && arb_grant && hit && !ch_bus.busy && !r.start) begin
            next_r.start = 1'b1;
            next_r.chan = hit_chan;
        end

        if (ch_bus.step) begin
            next_r.cur_addr[r.chan] = ch_bus.next_mem_addr;
            next_r.cur_count[r.chan] = ch_bus.next_count;
        end
        if (ch_bus.tc) begin
            // Set wins over a same-cycle clear
            next_r.tc_status[r.chan] = 1'b1;
            next_r.mode[r.chan][MODE_ENABLE] = 1'b0;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            r <= '0;
            r.level0 <= LEVEL0_RESET;
            r.level4 <= LEVEL4_RESET;
        end else begin
            r <= next_r;
        end
    end

    // ************************************************
    // Sequencer
    // ************************************************
    assign ch_bus.start = r.start;
    assign ch_bus.chan = r.chan;
    assign ch_bus.mode = r.mode[r.chan];
    assign ch_bus.mem_addr = r.cur_addr[r.chan];
    assign ch_bus.io_addr = r.io_addr[r.chan];
    assign ch_bus.count = r.cur_count[r.chan];

    dma_xfer_seq u_seq (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .ch(ch_bus),
        .slot_channel_ready(slot_channel_ready),
        .bus_rdata(bus_rdata),
        .bus_cycle(bus_cycle),
        .bus_mem(bus_mem),
        .bus_write(bus_write),
        .bus_word(bus_word),
        .bus_addr(bus_addr),
        .bus_wdata(bus_wdata)
    );

    // ************************************************
    // Outputs
    // ************************************************
    // Zero-wait slave keeps the host path simple
    assign pready = 1'b1;
    assign pslverr = 1'b0;
    assign prdata = r.rdata;
    assign active_chan = r.chan;
    assign busy = ch_bus.busy | r.start;
    assign irq = |(r.tc_status & r.irq_en);
endmodule

// *** rtl/dma_xfer_seq.sv ***
`timescale 1ns/1ps
module dma_xfer_seq
    import dma_core_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rst_n,
    dma_chan_if.seq ch,
    input wire logic slot_channel_ready,
    input wire logic [DATA_W-1:0] bus_rdata,
    output logic bus_cycle,
    output logic bus_mem,
    output logic bus_write,
    output logic bus_word,
    output logic [MEM_ADDR_W-1:0] bus_addr,
    output logic [DATA_W-1:0] bus_wdata
);
    typedef struct packed {
        xfer_state_t state;
        logic [DATA_W-1:0] hold;
        logic [MEM_ADDR_W-1:0] addr;
        logic [COUNT_W-1:0] count;
        logic [MODE_W-1:0] mode;
        logic [IO_ADDR_W-1:0] io;
        logic step;
        logic tc;
    } seq_state_t;

    seq_state_t r, next_r;
    logic rd_is_mem;

    always_comb begin
        next_r = r;
        next_r.step = 1'b0;
        next_r.tc = 1'b0;
        rd_is_mem = r.mode[MODE_MEM_TO_IO] | r.mode[MODE_VERIFY];
        case (r.state)
            XF_IDLE: begin
                if (ch.start) begin
                    next_r.addr = ch.mem_addr;
                    next_r.count = ch.count;
                    next_r.mode = ch.mode;
                    next_r.io = ch.io_addr;
                    next_r.state = XF_READ;
                end
            end
            XF_READ: begin
                if (slot_channel_ready) begin
                    next_r.hold = bus_rdata;
                    next_r.state = r.mode[MODE_VERIFY] ? XF_NEXT : XF_WRITE;
                end
            end
            XF_WRITE: begin
                if (slot_channel_ready) begin
                    next_r.state = XF_NEXT;
                end
            end
            XF_NEXT: begin
                next_r.step = 1'b1;
                next_r.count = r.count - 1'b1;
                if (r.mode[MODE_DECREMENT]) begin
                    next_r.addr = r.addr - (r.mode[MODE_WORD] ? ADDR_STEP_WORD : ADDR_STEP_BYTE);
                end else begin
                    next_r.addr = r.addr + (r.mode[MODE_WORD] ? ADDR_STEP_WORD : ADDR_STEP_BYTE);
                end
                if (r.count == '0) begin
                    next_r.tc = 1'b1;
                    next_r.state = XF_DONE;
                end else if (r.mode[MODE_BURST]) begin
                    next_r.state = XF_READ;
                end else begin
                    next_r.state = XF_DONE;
                end
            end
            XF_DONE: begin
                next_r.state = XF_IDLE;
            end
            default: begin
                next_r.state = XF_IDLE;
            end
        endcase
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            r <= '0;
        end else begin
            r <= next_r;
        end
    end

    // Bus fields are decoded from registered state only
    always_comb begin
        bus_cycle = (r.state == XF_READ) || (r.state == XF_WRITE);
        bus_write = (r.state == XF_WRITE);
        bus_word = r.mode[MODE_WORD];
        bus_mem = (r.state == XF_READ) ? rd_is_mem : ~rd_is_mem;
        if (bus_mem) begin
            bus_addr = r.addr;
        end else if (r.mode[MODE_USE_IO_ADDR]) begin
            bus_addr = {{(MEM_ADDR_W-IO_ADDR_W){1'b0}}, r.io};
        end else begin
            bus_addr = {{(MEM_ADDR_W-IO_ADDR_W){1'b0}}, IO_ADDR_FORCED};
        end
    end

    assign bus_wdata = r.hold;
    assign ch.step = r.step;
    assign ch.tc = r.tc;
    assign ch.next_mem_addr = r.addr;
    assign ch.next_count = r.count;
    assign ch.busy = (r.state != XF_IDLE);
endmodule

// *** tb/dma_core_assertions.sv ***
`timescale 1ns/1ps
module dma_core_assertions
    import dma_core_pkg::*;
#(
    parameter int CHANNELS = NUM_CHANNELS
)
(
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic psel,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic arb_grant,
    input wire logic slot_channel_ready,
    input wire logic [DATA_W-1:0] bus_rdata,
    input wire logic bus_cycle,
    input wire logic bus_mem,
    input wire logic bus_write,
    input wire logic bus_word,
    input wire logic [MEM_ADDR_W-1:0] bus_addr,
    input wire logic [DATA_W-1:0] bus_wdata,
    input wire logic [CH_IDX_W-1:0] active_chan,
    input wire logic busy,
    input wire logic irq
);
    // ****************************************
    // Shadow of the holding latch
    // ****************************************
    logic [DATA_W-1:0] last_rd;
    always_ff @(posedge sys_clk) begin
        if (bus_cycle && !bus_write && slot_channel_ready) begin
            last_rd <= bus_rdata;
        end
    end
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rst_n);
    stretch_hold_a: assert property (bus_cycle && !slot_channel_ready |=>
        bus_cycle && $stable(bus_addr) && $stable(bus_write) && $stable(bus_mem))
        else $error("access not held while ready low");
    write_data_a: assert property (bus_cycle && bus_write |->
        (bus_word ? bus_wdata : {8'h00, bus_wdata[7:0]}) ==
        (bus_word ? last_rd : {8'h00, last_rd[7:0]})) else $error("write data not latched");
    read_end_a: assert property (bus_cycle && !bus_write && slot_channel_ready |=>
        !bus_cycle || (bus_write && bus_mem != $past(bus_mem)))
        else $error("read not followed by write on other side");
    write_end_a: assert property (bus_cycle && bus_write && slot_channel_ready |=>
        !bus_cycle) else $error("write cycle not closed");
    io_addr_a: assert property (bus_cycle && !bus_mem |-> bus_addr[23:16] == 8'h00)
        else $error("io address wider than 16 bits");
    apb_ok_a: assert property (psel |-> pready && !pslverr)
        else $error("register access refused");
    start_grant_a: assert property ($rose(busy) |-> $past(arb_grant) || $past(arb_grant, 2))
        else $error("service began without grant");
    start_bound_a: assert property ($rose(busy) |-> ##[0:2] (bus_cycle && !bus_write))
        else $error("service did not open with a read");
    cycle_busy_a: assert property (bus_cycle |-> busy)
        else $error("bus cycle outside service");
    chan_hold_a: assert property (bus_cycle |=> !bus_cycle || $stable(active_chan))
        else $error("channel changed mid access");
    cover property (bus_cycle && !slot_channel_ready);
    cover property (bus_cycle && bus_write && !bus_mem);
    cover property ($rose(irq));
endmodule

bind dma_core dma_core_assertions #(.CHANNELS(CHANNELS)) dma_core_assertions_inst (.*);

// *** tb/dma_core_bench.sv ***
`timescale 1ns/1ps
module dma_core_bench;
    import dma_core_pkg::*;
    `define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin bad_count++; \
        $display("MISMATCH %s exp %0h got %0h", nm, e, g); end end
    logic sys_clk = 0;
    logic rst_n = 0;
    logic psel = 0;
    logic penable = 0;
    logic pwrite = 0;
    logic arb_grant = 0;
    logic [11:0] paddr = 0;
    logic [31:0] pwdata = 0;
    logic [LEVEL_W-1:0] arb_level = 0;
    logic [31:0] prdata;
    logic pready, pslverr, slot_channel_ready, bus_cycle, bus_mem, bus_write, bus_word, busy, irq;
    logic [DATA_W-1:0] bus_rdata, bus_wdata;
    logic [MEM_ADDR_W-1:0] bus_addr, exp_mem, src_addr;
    logic [CH_IDX_W-1:0] active_chan;
    logic [MODE_W-1:0] mode;
    logic [IO_ADDR_W-1:0] io;
    logic [31:0] rd;
    logic src_mem;
    int bad_count = 0;
    int n_compared = 0;
    int cycles = 0;
    int n_mem = 0;
    int n_wr = 0;
    integer seed = 32'h6146;
    always #5 sys_clk = ~sys_clk;
    dma_core dma_core_inst (.*);
    dma_slave_model dma_slave_model_inst (.sys_clk, .rst_n, .bus_cycle, .bus_mem, .bus_write,
        .bus_addr, .slot_channel_ready, .bus_rdata);
    // ****************************************
    // Helpers
    // ****************************************
    function logic [15:0] msk();
        return mode[MODE_WORD] ? 16'hFFFF : 16'h00FF;
    endfunction
    function logic [15:0] pat(input logic m, input logic [23:0] a);
        return a[15:0] ^ (m ? 16'hA5C3 : 16'h3C5A);
    endfunction
    function logic [11:0] caddr(input logic [2:0] c, input logic [4:0] o);
        return CH_BASE + 12'(c) * CH_STRIDE + {7'h00, o};
    endfunction
    task end_sim();
        $display("compared %0d mismatches %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge sys_clk);
        penable <= 1'b1;
        @(posedge sys_clk);
        while (pready !== 1'b1) @(posedge sys_clk);
        rd = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    // Grant held until service starts, so a slow start is never missed
    task grant_once(input logic [3:0] l);
        @(posedge sys_clk);
        arb_level <= l;
        arb_grant <= 1'b1;
        @(posedge sys_clk);
        while (busy !== 1'b1) @(posedge sys_clk);
        arb_grant <= 1'b0;
        while (busy !== 1'b0) @(posedge sys_clk);
    endtask
    // ****************************************
    // Bus monitor and timeout
    // ****************************************
    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 20000) begin
            bad_count++;
            end_sim();
        end
        if (rst_n && bus_cycle && slot_channel_ready) begin
            if (bus_mem) begin
                `CHK("mem_addr", exp_mem, bus_addr)
                `CHK("width", mode[MODE_WORD], bus_word)
                n_mem++;
                exp_mem = mode[MODE_DECREMENT] ? exp_mem - (mode[MODE_WORD] ? ADDR_STEP_WORD :
                    ADDR_STEP_BYTE) : exp_mem + (mode[MODE_WORD] ? ADDR_STEP_WORD : ADDR_STEP_BYTE);
            end else begin
                `CHK("io_addr", {8'h00, mode[MODE_USE_IO_ADDR] ? io : IO_ADDR_FORCED}, bus_addr)
            end
            if (!bus_write) begin
                `CHK("read_side", mode[MODE_MEM_TO_IO] | mode[MODE_VERIFY], bus_mem)
                src_addr = bus_addr;
                src_mem = bus_mem;
            end else begin
                n_wr++;
                `CHK("wdata", pat(src_mem, src_addr) & msk(), bus_wdata & msk())
            end
        end
    end
    // ****************************************
    // One programmed service, start to terminal count
    // ****************************************
    task run_case(input int t);
        logic [2:0] ch;
        logic [15:0] cnt;
        logic [3:0] lvl;
        logic [23:0] mem;
        int g;
        ch = (t < 8) ? t[2:0] : 3'($random(seed));
        mode = 7'($random(seed)) | 7'h01;
        if (t < 8) mode[3:1] = t[2:0];
        cnt = (t == 1) ? 16'h0000 : 16'($random(seed)) & 16'h0003;
        mem = 24'($random(seed));
        io = 16'($random(seed));
        lvl = (ch == 0 || ch == 4) ? 4'h8 | 4'($random(seed)) : 4'(ch);
        if (ch == 0 || ch == 4) begin
            apb(1'b1, ch == 0 ? REG_LEVEL0 : REG_LEVEL4, 32'(lvl));
            apb(1'b0, ch == 0 ? REG_LEVEL0 : REG_LEVEL4, 32'h0000_0000);
            `CHK("level", lvl, rd[3:0])
        end
        apb(1'b1, caddr(ch, CH_MEM_ADDR), 32'(mem));
        apb(1'b1, caddr(ch, CH_IO_ADDR), 32'(io));
        apb(1'b1, caddr(ch, CH_COUNT), 32'(cnt));
        apb(1'b0, caddr(ch, CH_CUR_ADDR), 32'h0000_0000);
        `CHK("cur_addr_load", mem, rd[23:0])
        apb(1'b0, caddr(ch, CH_CUR_COUNT), 32'h0000_0000);
        `CHK("cur_count_load", cnt, rd[15:0])
        exp_mem = mem;
        n_mem = 0;
        n_wr = 0;
        apb(1'b1, caddr(ch, CH_MODE), 32'(mode));
        apb(1'b1, REG_CONTROL, 32'h0000_0001);
        g = 0;
        rd = 32'h0000_0000;
        while (rd[ch] !== 1'b1 && g < 40) begin
            grant_once(lvl);
            g++;
            apb(1'b0, REG_STATUS, 32'h0000_0000);
        end
        `CHK("grants", mode[MODE_BURST] ? 1 : int'(cnt) + 1, g)
        `CHK("transfers", int'(cnt) + 1, n_mem)
        `CHK("writes", mode[MODE_VERIFY] ? 0 : int'(cnt) + 1, n_wr)
        arb_level <= lvl;
        arb_grant <= 1'b1;
        apb(1'b0, caddr(ch, CH_IO_ADDR), 32'h0000_0000);
        arb_grant <= 1'b0;
        `CHK("io_kept", io, rd[15:0])
        apb(1'b0, caddr(ch, CH_CUR_ADDR), 32'h0000_0000);
        `CHK("cur_addr", exp_mem, rd[23:0])
        apb(1'b0, caddr(ch, CH_CUR_COUNT), 32'h0000_0000);
        `CHK("cur_count_end", cnt - (cnt + 16'h0001), rd[15:0])
        apb(1'b0, caddr(ch, CH_MODE), 32'h0000_0000);
        `CHK("mode_off", mode & ~(7'(1) << MODE_ENABLE), rd[MODE_W-1:0])
        `CHK("active_chan", ch, active_chan)
        `CHK("no_more", int'(cnt) + 1, n_mem)
        `CHK("irq_on", 1'b1, irq)
        apb(1'b1, REG_IRQ_ENABLE, 32'h0000_0000);
        apb(1'b0, REG_STATUS, 32'h0000_0000);
        `CHK("irq_masked", 1'b0, irq)
        `CHK("tc_bit", 9'(1) << ch, rd[8:0])
        apb(1'b1, REG_IRQ_ENABLE, 32'h0000_00FF);
        apb(1'b1, REG_IRQ_CLEAR, 32'(1) << ch);
        apb(1'b0, REG_STATUS, 32'h0000_0000);
        `CHK("cleared", 9'h000, rd[8:0])
        `CHK("irq_off", 1'b0, irq)
    endtask
    initial begin
        repeat (4) @(posedge sys_clk);
        rst_n <= 1'b1;
        apb(1'b0, REG_LEVEL4, 32'h0000_0000);
        `CHK("level4_reset", 32'(LEVEL4_RESET), rd)
        apb(1'b0, 12'hFFC, 32'h0000_0000);
        `CHK("unmapped", BAD_READ, rd)
        apb(1'b1, REG_IRQ_ENABLE, 32'h0000_00FF);
        for (int t = 0; t < 12; t++) begin
            run_case(t);
        end
        end_sim();
    end
endmodule

// *** tb/dma_slave_model.sv ***
`timescale 1ns/1ps
module dma_slave_model
    import dma_core_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic bus_cycle,
    input wire logic bus_mem,
    input wire logic bus_write,
    input wire logic [MEM_ADDR_W-1:0] bus_addr,
    output logic slot_channel_ready,
    output logic [DATA_W-1:0] bus_rdata
);
    // ****************************************
    // Memory and slave data
    // ****************************************
    integer seed = 32'h6146;
    logic [DATA_W-1:0] pat;
    assign pat = bus_addr[15:0] ^ (bus_mem ? 16'hA5C3 : 16'h3C5A);
    // Idle bus shows the inverse so a stale value never looks valid
    assign bus_rdata = (bus_cycle && !bus_write) ? pat : ~pat;
    initial slot_channel_ready = 1'b1;
    // Slow slave: about one edge in three is stretched
    always @(posedge sys_clk) begin
        if (!rst_n) begin
            slot_channel_ready <= 1'b1;
        end else begin
            slot_channel_ready <= ($random(seed) % 3) != 0;
        end
    end
endmodule
